// ### shared/dbf_consts.svh
// Constants for the download data block framer: register offsets,
// reset values, fixed field codes and packet geometry.
// Assumes inclusion by the framer module and the testbench only.
`ifndef DBF_CONSTS_SVH
`define DBF_CONSTS_SVH

`define DBF_ADDR_CTRL      8'h00
`define DBF_ADDR_PID       8'h04
`define DBF_ADDR_MODID     8'h08
`define DBF_ADDR_MODVER    8'h0c
`define DBF_ADDR_BLKNUM    8'h10
`define DBF_ADDR_LASTSEC   8'h14
`define DBF_ADDR_DLID      8'h18
`define DBF_ADDR_PAYLEN    8'h1c
`define DBF_ADDR_CHKSUM    8'h20
`define DBF_ADDR_STATUS    8'h24

`define DBF_PID_RST        13'h00ff
`define DBF_PAYLEN_RST     8'h00

`define DBF_SYNC_BYTE      8'h47
`define DBF_POINTER        8'h00
`define DBF_TABLE_ID       8'h3c
`define DBF_PROTO_DISC     8'h11
`define DBF_MSG_TYPE       8'h03
`define DBF_MSG_ID         16'h1003
`define DBF_STUFF          8'hff
`define DBF_RSVD_BYTE      8'hff
`define DBF_ADAPT_LEN      8'h00
`define DBF_SCRAMBLE       2'b00
`define DBF_AFC_PAYLOAD    2'b01

`define DBF_PKT_LEN        8'd188
`define DBF_PKT_LAST       8'd187
`define DBF_HDR_LEN        9'd31
`define DBF_PAY_MAX        8'd153
`define DBF_SEC_LEN_BASE   12'd27
`define DBF_MSG_LEN_BASE   16'd6

`endif

// ### shared/dbf_pkg.sv
// Types shared by the download data block framer.
// Assumes dbf_consts.svh is on the include path.
`default_nettype none
package dbf_pkg;

    typedef enum logic [0:0] {
        DBF_IDLE = 1'b0,
        DBF_RUN  = 1'b1
    } dbf_phase_t;

    // One byte of the outgoing transport stream packet.
    typedef struct packed {
        logic       valid;
        logic       sop;
        logic       eop;
        logic [7:0] data;
    } dbf_ts_t;

    // Carousel parameters as written by software.
    typedef struct packed {
        logic [12:0] pid;
        logic [15:0] module_id;
        logic [7:0]  module_ver;
        logic [15:0] block_num;
        logic [7:0]  last_sec;
        logic [31:0] download_id;
        logic [7:0]  pay_len;
        logic [31:0] checksum;
    } dbf_cfg_t;

    typedef struct packed {
        dbf_phase_t  phase;
        logic [7:0]  idx;
        logic [3:0]  cc;
        logic [15:0] pkt_cnt;
        dbf_ts_t     out;
        dbf_cfg_t    cfg;
        logic [31:0] rdata;
    } dbf_state_t;

endpackage : dbf_pkg
`default_nettype wire

// ### logic/dbf_framer.sv
// Download data block framer: builds one 188-byte transport stream packet
// carrying a single download data block section per start command.
// Assumes a single 20 MHz clock, a plain register port, a byte source with
// valid/ready and a downstream sink with ready that may stall.
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "dbf_consts.svh"

module dbf_framer (
    input  wire logic           MCLK,
    input  wire logic           RST,
    input  wire logic [7:0]     ADDR,
    input  wire logic [31:0]    WDATA,
    input  wire logic           WR,
    input  wire logic           RD,
    output logic      [31:0]    RDATA,
    input  wire logic [7:0]     SRC_DATA,
    input  wire logic           SRC_VALID,
    output logic                SRC_READY,
    output dbf_pkg::dbf_ts_t    TS_OUT,
    input  wire logic           TS_READY,
    output logic                BUSY
);

    dbf_pkg::dbf_state_t q;
    dbf_pkg::dbf_state_t next_q;

    // Payload longer than the packet can hold is cut to what fits.
    function automatic logic [7:0] dbf_clamp(input logic [7:0] len);
        dbf_clamp = (len > `DBF_PAY_MAX) ? `DBF_PAY_MAX : len;
    endfunction : dbf_clamp

    // Header, checksum and stuffing byte at a packet position.
    function automatic logic [7:0] dbf_byte(input logic [7:0] idx,
                                            input dbf_pkg::dbf_cfg_t c,
                                            input logic [3:0] cc,
                                            input logic [7:0] len);
        logic [11:0] sec_len;
        logic [15:0] msg_len;
        logic [8:0]  sum_pos;
        sec_len = `DBF_SEC_LEN_BASE + {4'h0, len};
        msg_len = `DBF_MSG_LEN_BASE + {8'h00, len};
        sum_pos = `DBF_HDR_LEN + {1'b0, len};
        dbf_byte = `DBF_STUFF;
        unique case (idx)
            8'd0:  dbf_byte = `DBF_SYNC_BYTE;
            8'd1:  dbf_byte = {1'b0, 1'b1, 1'b0, c.pid[12:8]};
            8'd2:  dbf_byte = c.pid[7:0];
            8'd3:  dbf_byte = {`DBF_SCRAMBLE, `DBF_AFC_PAYLOAD, cc};
            8'd4:  dbf_byte = `DBF_POINTER;
            8'd5:  dbf_byte = `DBF_TABLE_ID;
            8'd6:  dbf_byte = {1'b0, 1'b1, 2'b11, sec_len[11:8]};
            8'd7:  dbf_byte = sec_len[7:0];
            8'd8:  dbf_byte = c.module_id[15:8];
            8'd9:  dbf_byte = c.module_id[7:0];
            8'd10: dbf_byte = {2'b11, c.module_ver[4:0], 1'b1};
            8'd11: dbf_byte = c.block_num[7:0];
            8'd12: dbf_byte = c.last_sec;
            8'd13: dbf_byte = `DBF_PROTO_DISC;
            8'd14: dbf_byte = `DBF_MSG_TYPE;
            8'd15: dbf_byte = 8'(`DBF_MSG_ID >> 8);
            8'd16: dbf_byte = 8'(`DBF_MSG_ID);
            8'd17: dbf_byte = c.download_id[31:24];
            8'd18: dbf_byte = c.download_id[23:16];
            8'd19: dbf_byte = c.download_id[15:8];
            8'd20: dbf_byte = c.download_id[7:0];
            8'd21: dbf_byte = `DBF_RSVD_BYTE;
            8'd22: dbf_byte = `DBF_ADAPT_LEN;
            8'd23: dbf_byte = msg_len[15:8];
            8'd24: dbf_byte = msg_len[7:0];
            8'd25: dbf_byte = c.module_id[15:8];
            8'd26: dbf_byte = c.module_id[7:0];
            8'd27: dbf_byte = c.module_ver;
            8'd28: dbf_byte = `DBF_RSVD_BYTE;
            8'd29: dbf_byte = c.block_num[15:8];
            8'd30: dbf_byte = c.block_num[7:0];
            default: begin
                // The word is sent as written; zero tells the receiver to skip the check.
                if ({1'b0, idx} == sum_pos) begin
                    dbf_byte = c.checksum[31:24];
                end else if ({1'b0, idx} == sum_pos + 9'd1) begin
                    dbf_byte = c.checksum[23:16];
                end else if ({1'b0, idx} == sum_pos + 9'd2) begin
                    dbf_byte = c.checksum[15:8];
                end else if ({1'b0, idx} == sum_pos + 9'd3) begin
                    dbf_byte = c.checksum[7:0];
                end
            end
        endcase
    endfunction : dbf_byte

    logic [7:0] len;
    logic       is_pay;
    logic       out_free;
    logic       emit;

    always_comb begin
        next_q = q;
        next_q.rdata = 32'h0000_0000;
        len = dbf_clamp(q.cfg.pay_len);
        is_pay = ({1'b0, q.idx} >= `DBF_HDR_LEN) &&
                 ({1'b0, q.idx} < `DBF_HDR_LEN + {1'b0, len});
        out_free = !q.out.valid || TS_READY;
        // A payload byte goes out only when the source has one, so the
        // source stalls the packet rather than the packet skipping data.
        emit = (q.phase == dbf_pkg::DBF_RUN) && out_free && (!is_pay || SRC_VALID);
        SRC_READY = (q.phase == dbf_pkg::DBF_RUN) && out_free && is_pay;
        if (out_free) begin
            next_q.out.valid = 1'b0;
        end
        if (emit) begin
            next_q.out.valid = 1'b1;
            next_q.out.sop = (q.idx == 8'd0);
            next_q.out.eop = (q.idx == `DBF_PKT_LAST);
            next_q.out.data = is_pay ? SRC_DATA : dbf_byte(q.idx, q.cfg, q.cc, len);
            next_q.idx = q.idx + 8'd1;
            if (q.idx == `DBF_PKT_LAST) begin
                next_q.phase = dbf_pkg::DBF_IDLE;
                next_q.cc = q.cc + 4'h1;
                next_q.pkt_cnt = q.pkt_cnt + 16'h0001;
            end
        end
        if (WR) begin
            unique case (ADDR)
                `DBF_ADDR_CTRL: begin
                    // A start while a packet is in flight is ignored.
                    if (WDATA[0] && q.phase == dbf_pkg::DBF_IDLE) begin
                        next_q.phase = dbf_pkg::DBF_RUN;
                        next_q.idx = 8'd0;
                    end
                    if (WDATA[1]) begin
                        next_q.cc = 4'h0;
                    end
                end
                `DBF_ADDR_PID:     next_q.cfg.pid = WDATA[12:0];
                `DBF_ADDR_MODID:   next_q.cfg.module_id = WDATA[15:0];
                `DBF_ADDR_MODVER:  next_q.cfg.module_ver = WDATA[7:0];
                `DBF_ADDR_BLKNUM:  next_q.cfg.block_num = WDATA[15:0];
                `DBF_ADDR_LASTSEC: next_q.cfg.last_sec = WDATA[7:0];
                `DBF_ADDR_DLID:    next_q.cfg.download_id = WDATA;
                `DBF_ADDR_PAYLEN:  next_q.cfg.pay_len = WDATA[7:0];
                `DBF_ADDR_CHKSUM:  next_q.cfg.checksum = WDATA;
                default: begin
                end
            endcase
        end
        if (RD) begin
            unique case (ADDR)
                `DBF_ADDR_PID:     next_q.rdata = {19'h0, q.cfg.pid};
                `DBF_ADDR_MODID:   next_q.rdata = {16'h0, q.cfg.module_id};
                `DBF_ADDR_MODVER:  next_q.rdata = {24'h0, q.cfg.module_ver};
                `DBF_ADDR_BLKNUM:  next_q.rdata = {16'h0, q.cfg.block_num};
                `DBF_ADDR_LASTSEC: next_q.rdata = {24'h0, q.cfg.last_sec};
                `DBF_ADDR_DLID:    next_q.rdata = q.cfg.download_id;
                `DBF_ADDR_PAYLEN:  next_q.rdata = {24'h0, q.cfg.pay_len};
                `DBF_ADDR_CHKSUM:  next_q.rdata = q.cfg.checksum;
                `DBF_ADDR_STATUS:  next_q.rdata = {q.pkt_cnt, 8'h0, q.cc, 3'h0,
                                                   q.phase == dbf_pkg::DBF_RUN};
                default:           next_q.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            q <= '0;
            q.cfg.pid <= `DBF_PID_RST;
            q.cfg.pay_len <= `DBF_PAYLEN_RST;
        end else begin
            q <= next_q;
        end
    end

    assign RDATA = q.rdata;
    assign TS_OUT = q.out;
    assign BUSY = (q.phase == dbf_pkg::DBF_RUN);

endmodule : dbf_framer

`default_nettype wire

// ### verif/dbf_framer_chk.sv
// Assertions on the packet stream and register port of the framer.
// Assumes a bind onto dbf_framer; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module dbf_framer_chk (
    input wire logic             MCLK,
    input wire logic             RST,
    input wire logic             RD,
    input wire logic [31:0]      RDATA,
    input wire logic             SRC_READY,
    input wire dbf_pkg::dbf_ts_t TS_OUT,
    input wire logic             TS_READY,
    input wire logic             BUSY
);
    logic [7:0] pos;
    always_ff @(posedge MCLK) begin
        if (RST) begin
            pos <= 8'h00;
        end else if (TS_OUT.valid && TS_READY) begin
            pos <= TS_OUT.eop ? 8'h00 : pos + 8'h01;
        end
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    sequence s_at(int p);
        TS_OUT.valid && pos == p;
    endsequence
    property p_sync; TS_OUT.sop |-> TS_OUT.valid && TS_OUT.data == 8'h47 && pos == 0; endproperty
    property p_eop; TS_OUT.valid |-> TS_OUT.eop == (pos == 8'd187); endproperty
    property p_pusi; s_at(1) |-> TS_OUT.data[7:5] == 3'b010; endproperty
    property p_afc; s_at(3) |-> TS_OUT.data[7:4] == 4'h1; endproperty
    property p_ptr; s_at(4) |-> TS_OUT.data == 8'h00; endproperty
    property p_tid; s_at(5) |-> TS_OUT.data == 8'h3c; endproperty
    property p_flag; s_at(6) |-> TS_OUT.data[7:4] == 4'h7; endproperty
    property p_cni; s_at(10) |-> TS_OUT.data[7:6] == 2'b11 && TS_OUT.data[0]; endproperty
    property p_hold; TS_OUT.valid && !TS_READY |=> $stable(TS_OUT); endproperty
    property p_rd; !$past(RD) |-> RDATA == 32'h0; endproperty
    property p_src; SRC_READY |-> BUSY && pos >= 8'd30; endproperty
    a_sync: assert property (p_sync) else $error("bad sync byte");
    a_eop: assert property (p_eop) else $error("bad packet end");
    a_pusi: assert property (p_pusi) else $error("bad start flag");
    a_afc: assert property (p_afc) else $error("bad scramble or afc");
    a_ptr: assert property (p_ptr) else $error("bad pointer");
    a_tid: assert property (p_tid) else $error("bad table id");
    a_flag: assert property (p_flag) else $error("bad section flags");
    a_cni: assert property (p_cni) else $error("bad current flag");
    a_hold: assert property (p_hold) else $error("byte changed in stall");
    a_rd: assert property (p_rd) else $error("read data without read");
    a_src: assert property (p_src) else $error("source taken outside payload");
endmodule : dbf_framer_chk
bind dbf_framer dbf_framer_chk dbf_framer_chk_i (.MCLK(MCLK), .RST(RST), .RD(RD),
    .RDATA(RDATA), .SRC_READY(SRC_READY), .TS_OUT(TS_OUT), .TS_READY(TS_READY), .BUSY(BUSY));
`default_nettype wire

// ### verif/dbf_far_model.sv
// Payload source and packet sink around the framer.
// Assumes the bench raises stall to make both sides slow.
`timescale 1ns/10ps
`default_nettype none
module dbf_far_model (
    input  wire logic             MCLK,
    input  wire logic             RST,
    input  wire logic             stall,
    input  wire dbf_pkg::dbf_ts_t ts_out,
    output logic                  ts_ready,
    input  wire logic             src_ready,
    output logic [7:0]            src_data,
    output logic                  src_valid,
    output logic [15:0]           pkts
);
    logic [7:0] pkt [188];
    logic [7:0] idx;
    logic [7:0] seq;
    logic [3:0] tick;
    logic       idle;
    always_ff @(posedge MCLK) begin
        if (RST) begin
            {idx, seq, tick, idle, pkts} <= '0;
        end else begin
            tick <= tick + 4'h1;
            if (ts_out.valid && ts_ready) begin
                pkt[idx] <= ts_out.data; // Every byte, checksum included, is stored for the bench to compare.
                idx <= ts_out.eop ? 8'h00 : idx + 8'h01;
                pkts <= pkts + 16'(ts_out.eop);
            end
            idle <= src_valid && src_ready && stall && seq[1:0] == 2'b10;
            if (src_valid && src_ready) begin
                seq <= seq + 8'h01;
            end
        end
    end
    // The source drops valid only after a handshake, so no offer is ever withdrawn.
    assign src_valid = !idle;
    assign ts_ready  = !stall || tick[1:0] != 2'b11;
    // Idle data shows the inverse so a stale byte never passes for a fresh one.
    assign src_data  = src_valid ? seq ^ 8'h5a : ~(seq ^ 8'h5a);
endmodule : dbf_far_model
`default_nettype wire

// ### verif/tb_download_data_block_framer.sv
// Self-checking bench for the framer: register reads, whole packets.
// Assumes dbf_framer, its checker bind and dbf_far_model.
`timescale 1ns/10ps
`default_nettype none
`include "dbf_consts.svh"
module tb_download_data_block_framer;
    logic MCLK, RST, WR, RD, SRC_VALID, SRC_READY, TS_READY, BUSY, stall;
    logic [7:0]       ADDR, SRC_DATA, seq_exp;
    logic [31:0]      WDATA, RDATA, d;
    logic [15:0]      pkts;
    logic [7:0]       exp [188];
    dbf_pkg::dbf_ts_t TS_OUT;
    int               fails, checked;
    dbf_framer dbf_framer_i (.MCLK(MCLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .SRC_DATA(SRC_DATA), .SRC_VALID(SRC_VALID),
        .SRC_READY(SRC_READY), .TS_OUT(TS_OUT), .TS_READY(TS_READY), .BUSY(BUSY));
    dbf_far_model dbf_far_model_i (.MCLK(MCLK), .RST(RST), .stall(stall), .ts_out(TS_OUT),
        .ts_ready(TS_READY), .src_ready(SRC_READY), .src_data(SRC_DATA),
        .src_valid(SRC_VALID), .pkts(pkts));
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        checked++;
        if (got !== want) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge MCLK);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge MCLK);
        WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge MCLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge MCLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask : rd
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    task automatic reset_regs();
        rd(`DBF_ADDR_PID);
        check(d, 32'h000000ff);
        rd(`DBF_ADDR_STATUS);
        check(d, 32'h0);
        rd(8'h30);
        check(d, 32'h0);
    endtask : reset_regs
    // One packet end to end; payload over 153 bytes is clamped by the framer.
    task automatic run_pkt(input logic [12:0] pid, input logic [15:0] mid, input logic [7:0] ver,
        input logic [15:0] blk, input logic [7:0] lst, input logic [31:0] dl,
        input logic [7:0] n, input logic [31:0] cs, input logic [3:0] cc);
        logic [247:0] hdr;
        logic [15:0]  was;
        logic [7:0]   k;
        k = (n > 8'd153) ? 8'd153 : n;
        hdr = {8'h47, 3'b010, pid, 4'h1, cc, 8'h00, 8'h3c, 4'h7, 12'(27 + k), mid, 2'b11,
            ver[4:0], 1'b1, blk[7:0], lst, 8'h11, 8'h03, 16'h1003, dl, 8'hff, 8'h00,
            16'(6 + k), mid, ver, 8'hff, blk};
        for (int i = 0; i < 188; i++) begin
            exp[i] = 8'hff;
        end
        for (int i = 0; i < 31; i++) begin
            exp[i] = hdr[247 - 8 * i -: 8];
        end
        for (int i = 0; i < k; i++) begin
            exp[31 + i] = seq_exp ^ 8'h5a;
            seq_exp++;
        end
        for (int i = 0; i < 4; i++) begin
            exp[31 + k + i] = cs[31 - 8 * i -: 8];
        end
        wr(`DBF_ADDR_PID, 32'(pid));
        wr(`DBF_ADDR_MODID, 32'(mid));
        wr(`DBF_ADDR_MODVER, 32'(ver));
        wr(`DBF_ADDR_BLKNUM, 32'(blk));
        wr(`DBF_ADDR_LASTSEC, 32'(lst));
        wr(`DBF_ADDR_DLID, dl);
        wr(`DBF_ADDR_PAYLEN, 32'(n));
        wr(`DBF_ADDR_CHKSUM, cs);
        rd(`DBF_ADDR_MODID);
        check(d, 32'(mid));
        rd(`DBF_ADDR_DLID);
        check(d, dl);
        rd(`DBF_ADDR_CHKSUM);
        check(d, cs);
        was = pkts;
        wr(`DBF_ADDR_CTRL, 32'h1);
        @(posedge MCLK);
        #1 check(32'(BUSY), 32'h1);
        // A second start in flight must not restart the packet.
        wr(`DBF_ADDR_CTRL, 32'h1);
        rd(`DBF_ADDR_STATUS);
        check(d, {was, 8'h00, cc, 4'h1});
        rd(`DBF_ADDR_CTRL);
        check(d, 32'h0);
        for (int t = 0; t < 3000 && pkts == was; t++) begin
            @(posedge MCLK);
        end
        #1 check(32'(BUSY), 32'h0);
        for (int i = 0; i < 188; i++) begin
            if (i < 31) check(32'(dbf_far_model_i.pkt[i]), 32'(exp[i]));
            else check(32'(dbf_far_model_i.pkt[i]), 32'(exp[i]));
        end
        rd(`DBF_ADDR_STATUS);
        check(d, {was + 16'h1, 8'h00, cc + 4'h1, 4'h0});
    endtask : run_pkt
    initial begin
        MCLK = 1'b0;
        forever #25 MCLK = ~MCLK;
    end
    initial begin
        repeat (40000) @(posedge MCLK);
        fails++;
        give_verdict();
    end
    initial begin
        {RST, WR, RD, ADDR, WDATA, stall, seq_exp, fails, checked} = '0;
        RST = 1'b1;
        repeat (12) @(posedge MCLK);
        RST <= 1'b0;
        reset_regs();
        run_pkt(13'h00ff, 16'h0002, 8'h00, 16'h0000, 8'h00, 32'h0, 8'd45, 32'h0, 4'h0);
        stall <= 1'b1;
        run_pkt(13'h1abc, 16'hbeef, 8'he7, 16'h0123, 8'h23, 32'hdeadbeef, 8'd200,
            32'h12345678, 4'h1);
        // Clearing the counter, then seventeen short packets to see it wrap.
        wr(`DBF_ADDR_CTRL, 32'h2);
        for (int j = 0; j < 17; j++) begin
            run_pkt(13'h0a5a, 16'h1234, 8'h1f, 16'(j), 8'h10, 32'h1, 8'(j), 32'h0, 4'(j));
        end
        give_verdict();
    end
endmodule : tb_download_data_block_framer
`default_nettype wire
